// ### design/adc_serial_command_pkg.sv
// constants, field layout and power states of the serial command interface
// assumes nothing of its surroundings; every user writes adc_serial_command_pkg::name
package adc_serial_command_pkg;

	// ---------------------------------------------------------------
	// command word layout
	// ---------------------------------------------------------------
	localparam int unsigned CMD_W          = 8;
	localparam logic [7:0]  CMD_RESET      = 8'h06;
	localparam int unsigned CHAN_MSB       = 7;
	localparam int unsigned CHAN_LSB       = 5;
	localparam int unsigned CHAN_W         = 3;
	localparam int unsigned SEQ_MSB        = 4;
	localparam int unsigned SEQ_LSB        = 3;
	localparam int unsigned PD_MSB         = 2;
	localparam int unsigned PD_LSB         = 1;
	localparam int unsigned CLK_SRC_BIT    = 0;

	localparam logic [1:0]  PD_ALL_ON      = 2'h0;
	localparam logic [1:0]  PD_ALL_OFF     = 2'h1;
	localparam logic [1:0]  PD_REF_ON      = 2'h2;
	localparam logic [1:0]  PD_EXT_REF     = 2'h3;
	localparam logic [1:0]  SEQ_SINGLE     = 2'h0;

	// ---------------------------------------------------------------
	// serial clock edge numbers within one frame (first edge is 1)
	// ---------------------------------------------------------------
	localparam int unsigned LINK_CNT_W     = 6;
	localparam logic [5:0]  EDGE_CHAN      = 6'h03;
	localparam logic [5:0]  EDGE_CFG_DONE  = 6'h08;
	localparam logic [5:0]  EDGE_SAMPLE_8  = 6'h06;
	localparam logic [5:0]  EDGE_SAMPLE_16 = 6'h0e;
	localparam logic [5:0]  EDGE_DATA_8    = 6'h08;
	localparam logic [5:0]  EDGE_DATA_16   = 6'h10;

	// ---------------------------------------------------------------
	// result format
	// ---------------------------------------------------------------
	localparam int unsigned RESULT_W       = 14;
	localparam int unsigned READ_BITS      = 16;

	// ---------------------------------------------------------------
	// reference wake time
	// ---------------------------------------------------------------
	localparam int unsigned CORE_CLK_MHZ   = 50;
	localparam int unsigned WAKE_TIME_US   = 5000;
	localparam int unsigned WAKE_CYCLES    = WAKE_TIME_US * CORE_CLK_MHZ;
	localparam int unsigned SETTLE_W       = 18;

	typedef enum logic [1:0] {
		PWR_BOTH_OFF = 2'b00,
		PWR_REF_ONLY = 2'b01,
		PWR_BOTH_ON  = 2'b11
	} power_state_type;

endpackage

// ### design/adc_serial_command_interface.sv
// serial command word, chip-select power control and external-clock readout
// assumes the host drives chip select, serial clock and command input; the
// serial clock runs only inside a frame, and the analog result is settled
// on sar_result_i at the sampling edge
//
// two clock domains: the link logic runs on the serial clock and, apart
// from the command shifter, is held in reset by chip select high; the
// setup word, power state and wake timer
// run on the core clock; three levels cross into the core domain through
// two flip-flops each, and the command word crosses as a bus held still
// while its synchronised valid level is picked up
//
// Overview of operation
// - shift command word from 1st rising edge
// - bits 7..5 select analog input 0..7
// - latch channel on 3rd rising edge
// - eight-channel scan field codes as given
// - four-channel scan field codes as given
// - scan honoured only with internal clock
// - power-down field selects reference/buffer state
// - enter chosen power-down at chip-select rise
// - wake on chip-select or frame-sync fall
// - bit 0 selects external or internal clock
// - chip select high: shutdown, output released
// - drive output low until result bits
// - 8-bit mode samples at 6th falling edge
// - 8-bit result MSB first from 8th fall
// - zeros after result until chip select rises
// - chip-select rise aborts conversion, shuts down
// - width select high gives 16-bit words
// - 16-bit mode samples at 14th falling edge
// - 16-bit result MSB first from 16th fall
// - power-up command word is 0x06
// - output changes on serial clock falls
// - result is unipolar straight binary, MSB first
module adc_serial_command_interface #(
	parameter int unsigned WAKE_CYCLES = adc_serial_command_pkg::WAKE_CYCLES
) (
	// core clock domain
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	// host link pins
	input  wire logic                 sclk_i,
	input  wire logic                 cs_n_i,
	input  wire logic                 din_i,
	input  wire logic                 frame_sync_in_i,
	input  wire logic                 word_width_sel_i,
	// converter result, settled at the sampling edge
	input  wire logic [13:0]          sar_result_i,
	// host data line
	output logic                      dout_o,
	output logic                      dout_oe_o,
	// converter and analog control
	output logic [2:0]                mux_channel_o,
	output logic                      track_o,
	output logic                      converting_o,
	output logic                      shutdown_o,
	output logic                      ref_on_o,
	output logic                      buf_on_o,
	output logic                      ref_ready_o,
	// setup word and its exported fields
	output logic [7:0]                setup_word_o,
	output logic [2:0]                cfg_channel_o,
	output logic [1:0]                cfg_seq_mode_o,
	output logic                      cfg_int_clock_o
);

	// ---------------------------------------------------------------
	// state types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [5:0] cnt;
		logic [7:0] cmd;
		logic [2:0] chan;
		logic       acq;
		logic       word_valid;
		logic       wsel_s1;
		logic       wsel_s2;
	} rise_state_type;

	typedef struct packed {
		logic [5:0]  cnt;
		logic [15:0] shreg;
		logic        conv;
		logic        dout;
	} fall_state_type;

	typedef struct packed {
		logic                                    cs_s1;
		logic                                    cs_s2;
		logic                                    cs_prev;
		logic                                    fs_s1;
		logic                                    fs_s2;
		logic                                    fs_prev;
		logic                                    vld_s1;
		logic                                    vld_s2;
		logic                                    vld_prev;
		logic [7:0]                              word;
		adc_serial_command_pkg::power_state_type pwr;
		logic [17:0]                             settle;
		logic                                    ready;
	} core_state_type;

	localparam core_state_type CORE_RESET = '{
		cs_s1:    1'b1,
		cs_s2:    1'b1,
		cs_prev:  1'b1,
		fs_s1:    1'b1,
		fs_s2:    1'b1,
		fs_prev:  1'b1,
		vld_s1:   1'b0,
		vld_s2:   1'b0,
		vld_prev: 1'b0,
		word:     adc_serial_command_pkg::CMD_RESET,
		pwr:      adc_serial_command_pkg::PWR_BOTH_OFF,
		settle:   18'h00000,
		ready:    1'b1
	};

	localparam logic [17:0] SETTLE_LAST = 18'(WAKE_CYCLES - 1);

	// ---------------------------------------------------------------
	// derived constants
	// ---------------------------------------------------------------
	localparam int unsigned      PAD_W      = adc_serial_command_pkg::READ_BITS - adc_serial_command_pkg::RESULT_W;
	localparam logic [PAD_W-1:0] PAD_ZERO   = '0;
	localparam logic [5:0]       EDGE_STEP  = 6'h01;
	localparam logic [17:0]      SETTLE_ONE = 18'h00001;

	rise_state_type rise_q;
	rise_state_type rise_d;
	fall_state_type fall_q;
	fall_state_type fall_d;
	core_state_type core_q;
	core_state_type core_d;

	// ---------------------------------------------------------------
	// link side, serial clock rising edges
	// ---------------------------------------------------------------
	// counts rising edges in the frame, shifts the command word and
	// raises word_valid once the word is whole
	always_comb begin
		logic [5:0] next_cnt;
		next_cnt = rise_q.cnt;
		rise_d   = rise_q;
		if (rise_q.cnt != '1) begin
			next_cnt = rise_q.cnt + EDGE_STEP;
		end
		rise_d.cnt     = next_cnt;
		rise_d.wsel_s1 = word_width_sel_i;
		rise_d.wsel_s2 = rise_q.wsel_s1;
		if (next_cnt <= adc_serial_command_pkg::EDGE_CFG_DONE) begin
			rise_d.cmd = {rise_q.cmd[6:0], din_i};
		end
		if (next_cnt == adc_serial_command_pkg::EDGE_CHAN) begin
			rise_d.chan = {rise_q.cmd[1:0], din_i};
			rise_d.acq  = 1'b1;
		end
		if (next_cnt == adc_serial_command_pkg::EDGE_CFG_DONE) begin
			rise_d.word_valid = 1'b1;
		end
	end

	// the command shifter keeps its value across chip-select high so the
	// core side can still pick it up after the frame has ended
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rise_q.cnt        <= '0;
			rise_q.chan       <= '0;
			rise_q.acq        <= 1'b0;
			rise_q.word_valid <= 1'b0;
			rise_q.wsel_s1    <= 1'b0;
			rise_q.wsel_s2    <= 1'b0;
		end else begin
			rise_q <= rise_d;
		end
	end

	// ---------------------------------------------------------------
	// link side, serial clock falling edges
	// ---------------------------------------------------------------
	always_comb begin
		logic [5:0] next_cnt;
		logic [5:0] sample_edge;
		logic [5:0] data_edge;
		logic       ext_clock;
		next_cnt    = fall_q.cnt;
		sample_edge = adc_serial_command_pkg::EDGE_SAMPLE_8;
		data_edge   = adc_serial_command_pkg::EDGE_DATA_8;
		ext_clock   = ~rise_q.cmd[adc_serial_command_pkg::CLK_SRC_BIT];
		fall_d      = fall_q;
		if (fall_q.cnt != '1) begin
			next_cnt = fall_q.cnt + EDGE_STEP;
		end
		// width select and the clock-source bit come from the rising-edge
		// side and stand still before the first falling edge that reads them
		if (rise_q.wsel_s2) begin
			sample_edge = adc_serial_command_pkg::EDGE_SAMPLE_16;
			data_edge   = adc_serial_command_pkg::EDGE_DATA_16;
		end
		fall_d.cnt = next_cnt;
		if (next_cnt == sample_edge) begin
			// unipolar binary result padded to a whole read word
			fall_d.shreg = {sar_result_i, PAD_ZERO};
			fall_d.conv  = 1'b1;
		end
		if (next_cnt >= data_edge && ext_clock && fall_q.conv) begin
			fall_d.dout  = fall_q.shreg[adc_serial_command_pkg::READ_BITS - 1];
			fall_d.shreg = fall_q.shreg << 1;
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			fall_q <= '0;
		end else begin
			fall_q <= fall_d;
		end
	end

	// ---------------------------------------------------------------
	// link side outputs
	// ---------------------------------------------------------------
	assign dout_oe_o     = ~cs_n_i;
	assign dout_o        = fall_q.dout;
	assign mux_channel_o = rise_q.chan;
	assign track_o       = rise_q.acq & ~fall_q.conv;
	assign converting_o  = fall_q.conv;

	// ---------------------------------------------------------------
	// core side: crossings, setup word and power control
	// ---------------------------------------------------------------
	// the word crosses as a held bus qualified by a synchronised level;
	// the shifter cannot move again before chip select has toggled, which
	// takes far longer than the three core cycles the pickup needs
	always_comb begin
		logic                                    cs_rise;
		logic                                    cs_fall;
		logic                                    fs_fall;
		logic                                    wake;
		logic [1:0]                              pd_field;
		adc_serial_command_pkg::power_state_type sleep_state;
		core_d   = core_q;
		core_d.cs_s1    = cs_n_i;
		core_d.cs_s2    = core_q.cs_s1;
		core_d.cs_prev  = core_q.cs_s2;
		core_d.fs_s1    = frame_sync_in_i;
		core_d.fs_s2    = core_q.fs_s1;
		core_d.fs_prev  = core_q.fs_s2;
		core_d.vld_s1   = rise_q.word_valid;
		core_d.vld_s2   = core_q.vld_s1;
		core_d.vld_prev = core_q.vld_s2;
		cs_rise  = core_q.cs_s2 & ~core_q.cs_prev;
		cs_fall  = ~core_q.cs_s2 & core_q.cs_prev;
		fs_fall  = ~core_q.fs_s2 & core_q.fs_prev;
		// frame sync held high means serial-host operation
		wake     = core_q.fs_s2 ? cs_fall : fs_fall;
		pd_field = core_q.word[adc_serial_command_pkg::PD_MSB:adc_serial_command_pkg::PD_LSB];
		sleep_state = adc_serial_command_pkg::PWR_BOTH_OFF;
		unique case (pd_field)
			adc_serial_command_pkg::PD_ALL_ON:  sleep_state = adc_serial_command_pkg::PWR_BOTH_ON;
			adc_serial_command_pkg::PD_ALL_OFF: sleep_state = adc_serial_command_pkg::PWR_BOTH_OFF;
			adc_serial_command_pkg::PD_REF_ON:  sleep_state = adc_serial_command_pkg::PWR_REF_ONLY;
			adc_serial_command_pkg::PD_EXT_REF: sleep_state = adc_serial_command_pkg::PWR_BOTH_OFF;
		endcase

		if (core_q.vld_s2 && !core_q.vld_prev) begin
			core_d.word = rise_q.cmd;
		end

		// the wake timer runs only while reference and buffer are up, so a
		// stale count can never raise ready during shutdown
		if (!core_q.ready && core_q.pwr == adc_serial_command_pkg::PWR_BOTH_ON) begin
			core_d.settle = core_q.settle + SETTLE_ONE;
			if (core_q.settle == SETTLE_LAST) begin
				core_d.ready = 1'b1;
			end
		end

		if (cs_rise) begin
			core_d.pwr    = sleep_state;
			core_d.settle = '0;
			if (sleep_state != adc_serial_command_pkg::PWR_BOTH_ON) begin
				core_d.ready = pd_field == adc_serial_command_pkg::PD_EXT_REF;
			end
		end else if (wake && pd_field != adc_serial_command_pkg::PD_EXT_REF) begin
			core_d.pwr = adc_serial_command_pkg::PWR_BOTH_ON;
			if (core_q.pwr != adc_serial_command_pkg::PWR_BOTH_ON) begin
				// reference or buffer was down: hold ready low for the wake time
				core_d.ready  = 1'b0;
				core_d.settle = '0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			core_q <= CORE_RESET;
		end else begin
			core_q <= core_d;
		end
	end

	// ---------------------------------------------------------------
	// core side outputs
	// ---------------------------------------------------------------
	always_comb begin
		ref_on_o  = 1'b0;
		buf_on_o  = 1'b0;
		unique case (core_q.pwr)
			adc_serial_command_pkg::PWR_BOTH_OFF: begin
				ref_on_o = 1'b0;
				buf_on_o = 1'b0;
			end
			adc_serial_command_pkg::PWR_REF_ONLY: begin
				ref_on_o = 1'b1;
				buf_on_o = 1'b0;
			end
			adc_serial_command_pkg::PWR_BOTH_ON: begin
				ref_on_o = 1'b1;
				buf_on_o = 1'b1;
			end
			default: begin
				ref_on_o = 1'b0;
				buf_on_o = 1'b0;
			end
		endcase
	end

	assign shutdown_o      = core_q.cs_s2;
	assign ref_ready_o     = core_q.ready;
	// ---------------------------------------------------------------
	// setup field export
	// ---------------------------------------------------------------
	assign setup_word_o    = core_q.word;
	assign cfg_channel_o   = core_q.word[adc_serial_command_pkg::CHAN_MSB:adc_serial_command_pkg::CHAN_LSB];
	assign cfg_int_clock_o = core_q.word[adc_serial_command_pkg::CLK_SRC_BIT];
	// the scan codes only reach the sequencer in internal-clock serial-host
	// operation; the eight- and four-channel code tables share one field
	assign cfg_seq_mode_o  = (cfg_int_clock_o && core_q.fs_s2)
		? core_q.word[adc_serial_command_pkg::SEQ_MSB:adc_serial_command_pkg::SEQ_LSB]
		: adc_serial_command_pkg::SEQ_SINGLE;

endmodule // adc_serial_command_interface

// ### testbench/adc_serial_command_interface_chk.sv
// checker for the serial command interface, bound to its top ports
// assumes frames start with the link clock low
module adc_serial_command_interface_chk (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        sclk_i,
	input wire logic        cs_n_i,
	input wire logic        din_i,
	input wire logic        frame_sync_in_i,
	input wire logic        word_width_sel_i,
	input wire logic [13:0] sar_result_i,
	input wire logic        dout_o,
	input wire logic        dout_oe_o,
	input wire logic [2:0]  mux_channel_o,
	input wire logic        track_o,
	input wire logic        converting_o,
	input wire logic        ref_on_o,
	input wire logic        buf_on_o,
	input wire logic        ref_ready_o,
	input wire logic [7:0]  setup_word_o,
	input wire logic [1:0]  cfg_seq_mode_o
);
	// ---
	// frame tracking
	// ---
	logic [5:0] rise_q;
	logic [7:0] word_q;
	logic [5:0] first_w;
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			rise_q <= 6'h00;
		end else if (rise_q != 6'h3f) begin
			rise_q <= rise_q + 6'h01;
		end
	end
	// kept past chip select so a late pick-up by the core still compares
	always_ff @(posedge sclk_i) begin
		if (!cs_n_i && rise_q < 6'h08) begin
			word_q <= {word_q[6:0], din_i};
		end
	end
	assign first_w = word_width_sel_i ? 6'h10 : 6'h08;
	property p_chan;
		@(posedge sclk_i) disable iff (cs_n_i) rise_q == 6'h03 |-> mux_channel_o == word_q[2:0];
	endproperty
	property p_low;
		@(negedge sclk_i) disable iff (cs_n_i) rise_q <= 6'h08 |-> !dout_o;
	endproperty
	property p_samp8;
		@(posedge sclk_i) disable iff (cs_n_i) rise_q == 6'h05 && !word_width_sel_i
			|-> track_o && !converting_o ##1 !track_o && converting_o;
	endproperty
	property p_samp16;
		@(posedge sclk_i) disable iff (cs_n_i) rise_q == 6'h0d && word_width_sel_i
			|-> track_o && !converting_o ##1 !track_o && converting_o;
	endproperty
	property p_data;
		@(posedge sclk_i) disable iff (cs_n_i) !word_q[0] && rise_q >= first_w && rise_q < first_w + 6'h0e
			|-> dout_o == sar_result_i[first_w + 6'h0d - rise_q];
	endproperty
	property p_zero;
		@(posedge sclk_i) disable iff (cs_n_i) rise_q >= first_w + 6'h0e |-> !dout_o;
	endproperty
	property p_int;
		@(posedge sclk_i) disable iff (cs_n_i) word_q[0] && rise_q >= 6'h08 |-> !dout_o;
	endproperty
	property p_oe;
		@(posedge core_clk_i) disable iff (rst_i) dout_oe_o == !cs_n_i;
	endproperty
	property p_word;
		@(posedge core_clk_i) disable iff (rst_i) $changed(setup_word_o) |-> setup_word_o == word_q;
	endproperty
	property p_seq;
		@(posedge core_clk_i) disable iff (rst_i)
			cfg_seq_mode_o == ((setup_word_o[0] && frame_sync_in_i) ? setup_word_o[4:3] : 2'h0);
	endproperty
	property p_down;
		@(posedge core_clk_i) disable iff (rst_i) $rose(cs_n_i) && setup_word_o[2:1] == 2'h1
			|-> ##[1:5] !ref_on_o && !buf_on_o;
	endproperty
	property p_wake;
		@(posedge core_clk_i) disable iff (rst_i) $fell(cs_n_i) && frame_sync_in_i && setup_word_o[2:1] == 2'h1
			|-> ##[1:5] ref_on_o && buf_on_o && !ref_ready_o;
	endproperty
	a_chan: assert property (p_chan) else $error("channel not latched at third edge");
	a_low: assert property (p_low) else $error("data line not low before result");
	a_samp8: assert property (p_samp8) else $error("narrow sample edge wrong");
	a_samp16: assert property (p_samp16) else $error("wide sample edge wrong");
	a_data: assert property (p_data) else $error("result bit wrong");
	a_zero: assert property (p_zero) else $error("pad bit not zero");
	a_int: assert property (p_int) else $error("data driven with internal clock");
	a_oe: assert property (p_oe) else $error("enable does not follow chip select");
	a_word: assert property (p_word) else $error("setup word differs from shifted bits");
	a_seq: assert property (p_seq) else $error("scan field export wrong");
	a_down: assert property (p_down) else $error("no shutdown at chip select rise");
	a_wake: assert property (p_wake) else $error("no wake at chip select fall");
	c_narrow: cover property (@(posedge sclk_i) rise_q == 6'h15 && !word_width_sel_i);
	c_wide: cover property (@(posedge sclk_i) rise_q == 6'h1d && word_width_sel_i);
	c_wake: cover property (@(posedge core_clk_i) $fell(cs_n_i) && setup_word_o[2:1] == 2'h1);
endmodule // adc_serial_command_interface_chk

bind adc_serial_command_interface adc_serial_command_interface_chk u_chk (.core_clk_i, .rst_i, .sclk_i,
	.cs_n_i, .din_i, .frame_sync_in_i, .word_width_sel_i, .sar_result_i, .dout_o, .dout_oe_o,
	.mux_channel_o, .track_o, .converting_o, .ref_on_o, .buf_on_o, .ref_ready_o, .setup_word_o,
	.cfg_seq_mode_o);

// ### testbench/serial_host_model.sv
// serial host: chip select, link clock and command bits, reads the data line
// assumes its tasks are called one at a time
module serial_host_model (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i,
	input  wire logic dout_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic line_w;
	logic last_q;
	// a released line shows the inverse of its last level, never a kept value
	always @(dout_i, dout_oe_i) if (dout_oe_i) last_q = dout_i;
	assign line_w = dout_oe_i ? dout_i : !last_q;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	task automatic frame(input logic [7:0] cmd, input int n, input int hp, output logic [15:0] rd);
		int first;
		first = (n == 32) ? 16 : 8;
		rd = 16'h0000;
		#3 cs_n_o <= 1'b0;
		#(2 * hp);
		for (int i = 1; i <= n; i++) begin
			din_o <= (i <= 8) ? cmd[8 - i] : !din_o;
			#(hp);
			if (i > first && i <= first + 16) rd = {rd[14:0], line_w};
			sclk_o <= 1'b1;
			#(hp);
			sclk_o <= 1'b0;
		end
		#(hp);
		cs_n_o <= 1'b1;
		#(hp * 4);
	endtask
	task automatic hold_cs(input logic v);
		cs_n_o <= v;
	endtask
endmodule // serial_host_model

// ### testbench/adc_serial_command_interface_tb.sv
// self-checking bench for the serial command interface
// assumes the host model owns chip select, link clock and command input
module adc_serial_command_interface_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk_i, rst_i, frame_sync_in_i, word_width_sel_i;
	logic [13:0] sar_result_i;
	wire logic   sclk_i, cs_n_i, din_i;
	logic        dout_o, dout_oe_o, track_o, converting_o, shutdown_o;
	logic        ref_on_o, buf_on_o, ref_ready_o, cfg_int_clock_o;
	logic [2:0]  mux_channel_o, cfg_channel_o;
	logic [1:0]  cfg_seq_mode_o;
	logic [7:0]  setup_word_o, cmd;
	logic [15:0] rd, pwr_exp;
	int          fail_count, checked;
	adc_serial_command_interface #(.WAKE_CYCLES(20)) u_dut (.core_clk_i, .rst_i, .sclk_i, .cs_n_i, .din_i,
		.frame_sync_in_i, .word_width_sel_i, .sar_result_i, .dout_o, .dout_oe_o, .mux_channel_o, .track_o,
		.converting_o, .shutdown_o, .ref_on_o, .buf_on_o, .ref_ready_o, .setup_word_o, .cfg_channel_o,
		.cfg_seq_mode_o, .cfg_int_clock_o);
	serial_host_model u_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o),
		.dout_oe_i(dout_oe_o));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = !core_clk_i;
	end
	initial begin
		#500us;
		fail_count++;
		finish_test();
	end
	// ---
	// main sequence
	// ---
	initial begin
		fail_count = 0;
		checked = 0;
		rst_i = 1'b1;
		frame_sync_in_i = 1'b1;
		word_width_sel_i = 1'b0;
		sar_result_i = 14'h0000;
		cyc(16);
		check(16'(setup_word_o), 16'h0006);
		check(16'({ref_on_o, buf_on_o, dout_oe_o, shutdown_o}), 16'h0001);
		rst_i <= 1'b0;
		cyc(4);
		for (int k = 0; k < 8; k++) begin
			cmd = {3'(k), 2'(k), 2'(k), 1'b0};
			sar_result_i <= 14'h3fff - 14'(k * 1111);
			cyc(1);
			u_host.frame(cmd, 24, 24, rd);
			check(rd, {sar_result_i, 2'b00});
			cyc(24);
			check(16'(setup_word_o), 16'(cmd));
			check(16'({cfg_channel_o, shutdown_o}), 16'({3'(k), 1'b1}));
			check(16'(cfg_seq_mode_o), 16'h0000);
			pwr_exp = (k % 4 == 0) ? 16'h7 : (k % 4 == 2) ? 16'h4 : (k % 4 == 3) ? 16'h1 : 16'h0;
			check(16'({ref_on_o, buf_on_o, ref_ready_o}), pwr_exp);
		end
		for (int j = 0; j < 4; j++) begin
			u_host.frame({3'h5, 2'(j), 2'h3, 1'b1}, 24, 24, rd);
			check(rd, 16'h0000);
			cyc(8);
			check(16'({cfg_int_clock_o, cfg_seq_mode_o}), 16'(4 + j));
		end
		word_width_sel_i <= 1'b1;
		sar_result_i <= 14'h2a5c;
		cyc(2);
		u_host.frame(8'h66, 32, 24, rd);
		check(rd, 16'ha970);
		cyc(1);
		word_width_sel_i <= 1'b0;
		u_host.frame(8'h02, 10, 24, rd);
		check(16'({converting_o, track_o, dout_oe_o}), 16'h0000);
		cyc(8);
		check(16'({ref_on_o, buf_on_o, ref_ready_o}), 16'h0000);
		u_host.hold_cs(1'b0);
		cyc(6);
		check(16'({ref_on_o, buf_on_o, ref_ready_o}), 16'h0006);
		cyc(10);
		check(16'(ref_ready_o), 16'h0000);
		for (int n = 0; n < 40 && ref_ready_o !== 1'b1; n++) cyc(1);
		check(16'(ref_ready_o), 16'h0001);
		u_host.hold_cs(1'b1);
		cyc(8);
		finish_test();
	end
endmodule // adc_serial_command_interface_tb
